// file: verilog/analog_comparator_control_params.svh
// Register indices, field positions, reset values and widths for the comparator control block
`ifndef ANALOG_COMPARATOR_CONTROL_PARAMS_SVH
`define ANALOG_COMPARATOR_CONTROL_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define ACC_IDX_CMP_CTRL 8'h30
`define ACC_IDX_CONV_B 8'h7B
`define ACC_IDX_DIG_DIS 8'h40
`define ACC_IDX_IRQ_STATUS 8'h41
`define ACC_IDX_IRQ_MASK 8'h42

// ----------------------------------------------------------------
// Comparator control/status fields
// ----------------------------------------------------------------
`define ACC_BIT_POWER_OFF 7
`define ACC_BIT_BANDGAP 6
`define ACC_BIT_RESULT 5
`define ACC_BIT_FLAG 4
`define ACC_BIT_IRQ_EN 3
`define ACC_BIT_CAPTURE 2
`define ACC_BIT_MODE_HI 1
`define ACC_BIT_MODE_LO 0

// ----------------------------------------------------------------
// Converter control/status B and input disable fields
// ----------------------------------------------------------------
`define ACC_BIT_MUX_EN 6
`define ACC_BIT_TRIG_HI 2
`define ACC_BIT_TRIG_LO 0
`define ACC_BIT_NEG_DIS 1
`define ACC_BIT_POS_DIS 0

// ----------------------------------------------------------------
// Interrupt status/mask fields
// ----------------------------------------------------------------
`define ACC_BIT_IRQ_EVENT 0
`define ACC_BIT_IRQ_CHANGE 1

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define ACC_RST_BYTE 8'h00
`define ACC_RST_PAIR 2'h0
`define ACC_RST_TRIG 3'h0
`define ACC_CHANNELS 8
`define ACC_LEVEL_W 10
`define ACC_BANDGAP_LEVEL 10'h168
`define ACC_ADDR_W 10
`define ACC_SYNC_W 3

`endif

// file: verilog/analog_comparator_pkg.sv
// Types shared by the comparator control block
package analog_comparator_pkg;

  // ----------------------------------------------------------------
  // Event mode encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_TOGGLE = 2'b00,
    MODE_RESERVED = 2'b01,
    MODE_FALL = 2'b10,
    MODE_RISE = 2'b11
  } event_mode_t;

  // ----------------------------------------------------------------
  // Full register state of the control block
  // ----------------------------------------------------------------
  typedef struct packed {
    logic power_off;
    logic bandgap_sel;
    logic flag;
    logic irq_en;
    logic capture_route;
    event_mode_t event_mode;
    logic mux_en;
    logic [2:0] trig_sel;
    logic neg_buf_dis;
    logic pos_buf_dis;
    logic result_prev;
    logic capture;
    logic irq_req;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
    logic irq_line;
    logic [1:0] port_pins;
    logic ack;
    logic [7:0] rdata;
  } ctrl_state_t;

endpackage

// file: verilog/sync_two_flop.sv
// Two-flop synchroniser for a group of independent single-bit levels
`timescale 1ns/1ps
module sync_two_flop #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t state_q;
  sync_state_t state_d;

  initial begin
    if (WIDTH < 1) begin
      $error("sync_two_flop: WIDTH must be at least 1");
    end
  end

  // First stage feeds the second only; metastability settles there
  always_comb begin
    state_d = state_q;
    state_d.stage1 = async_in;
    state_d.stage2 = state_q.stage1;
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.stage2;

endmodule // sync_two_flop

// file: verilog/analog_comparator_control.sv
// Comparator input selection, result synchronisation, event detection and registers
`timescale 1ns/1ps
`include "analog_comparator_control_params.svh"

// Summary of operation
// [R1] Comparator result is high while selected positive level exceeds selected negative level.
// [R2] Result passes a two-flop synchroniser before being readable, one to two cycles.
// [R3] Mode field bits 1:0: toggle, reserved, falling, rising edge of result.
// [R4] Event flag bit 4 sets when a result transition matches the mode.
// [R5] Flag clears on vector taken or on write of one; zero leaves it.
// [R6] Interrupt request only while flag, enable bit 3 and global enable are set.
// [R7] Bit 7 one switches comparator power off; zero switches it on again.
// [R8] Software clears interrupt enable before changing power or mode bits.
// [R9] Bit 6 selects bandgap reference for positive input, else positive pin.
// [R10] Bit 2 routes result to timer capture front end, else no connection.
// [R11] Software also enables the timer capture interrupt for capture interrupts.
// [R12] Mux enable with converter off lets channel select pick channel 0 to 7.
// [R13] Mux enable off or converter on applies the negative pin instead.
// [R14] Mux enable is bit 6 of register B; bits 7,5,4,3 read zero.
// [R15] Software keeps converter power reduction off to use the multiplexer.
// [R16] Input disable bits turn off pin buffers; port bits then read zero.
// [R17] Reserved mode never sets the flag; edges compare consecutive result samples.
module analog_comparator_control #(
  parameter int LEVEL_W = `ACC_LEVEL_W,
  parameter int CHANNELS = `ACC_CHANNELS,
  parameter int ADDR_W = `ACC_ADDR_W,
  parameter logic [LEVEL_W-1:0] BANDGAP_LEVEL = `ACC_BANDGAP_LEVEL
) (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Wishbone classic slave
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [ADDR_W-1:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  // Analog levels, digitised model of the pin voltages
  input wire logic [LEVEL_W-1:0] positive_input_pin_in,
  input wire logic [LEVEL_W-1:0] negative_input_pin_in,
  input wire logic [CHANNELS*LEVEL_W-1:0] analog_channel_pins_in,
  // Digital pin levels for the port input path
  input wire logic positive_pin_digital_in,
  input wire logic negative_pin_digital_in,
  // Converter and processor context, same clock
  input wire logic converter_enable_in,
  input wire logic [2:0] channel_select_in,
  input wire logic global_irq_enable_in,
  input wire logic vector_taken_in,
  // Results
  output logic comparator_result_out,
  output logic capture_trigger_out,
  output logic compare_irq_request_out,
  output logic irq_out,
  output logic comparator_power_off_out,
  output logic [2:0] trigger_select_out,
  output logic positive_pin_buffer_disable_out,
  output logic negative_pin_buffer_disable_out,
  output logic [1:0] port_pins_out
);

  // ----------------------------------------------------------------
  // Parameter checks
  // ----------------------------------------------------------------
  initial begin
    if (ADDR_W < 10) begin
      $error("analog_comparator_control: ADDR_W must be at least 10");
    end
    if (CHANNELS != 8) begin
      $error("analog_comparator_control: channel select serves exactly 8 channels");
    end
    if (LEVEL_W < 1) begin
      $error("analog_comparator_control: LEVEL_W must be at least 1");
    end
    if (`ACC_SYNC_W != 3) begin
      $error("analog_comparator_control: synchroniser carries result and two pin levels");
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [LEVEL_W-1:0] channel_level(input logic [CHANNELS*LEVEL_W-1:0] pins,
                                                     input logic [2:0] sel);
    channel_level = pins[sel*LEVEL_W +: LEVEL_W];
  endfunction

  // Hardware set wins over any clear in the same cycle
  function automatic logic sticky_next(input logic cur, input logic set, input logic clr);
    sticky_next = set | (cur & ~clr);
  endfunction

  // Write strobe aimed at one register index
  function automatic logic write_hits(input logic w, input logic [7:0] i, input logic [7:0] t);
    write_hits = w && (i == t);
  endfunction

  // ----------------------------------------------------------------
  // Analog input selection and comparison
  // ----------------------------------------------------------------
  logic [LEVEL_W-1:0] pos_level;
  logic [LEVEL_W-1:0] neg_level;
  logic raw_result;
  logic [`ACC_SYNC_W-1:0] sync_in;
  logic [`ACC_SYNC_W-1:0] sync_q;
  logic result_sync;

  analog_comparator_pkg::ctrl_state_t state_q;
  analog_comparator_pkg::ctrl_state_t state_d;

  always_comb begin
    // [R9] Positive source select
    pos_level = state_q.bandgap_sel ? BANDGAP_LEVEL : positive_input_pin_in;
    // [R12] [R13] Negative source select
    if (state_q.mux_en && !converter_enable_in) begin
      neg_level = channel_level(analog_channel_pins_in, channel_select_in);
    end else begin
      neg_level = negative_input_pin_in;
    end
    // [R1] [R7] Compare, held low while powered off
    raw_result = !state_q.power_off && (pos_level > neg_level);
  end

  assign sync_in = {negative_pin_digital_in, positive_pin_digital_in, raw_result};

  // Pin levels share the synchroniser; each bit settles on its own
  // [R2] Synchronise result and pin levels
  sync_two_flop #(
    .WIDTH(`ACC_SYNC_W)
  ) u_sync (
    .clk_sys_in(clk_sys_in),
    .reset_in(reset_in),
    .async_in(sync_in),
    .sync_out(sync_q)
  );

  assign result_sync = sync_q[0];

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic req;
  logic wr;
  logic [7:0] idx;
  logic [7:0] wbyte;
  logic rise;
  logic fall;
  logic hit;
  logic flag_clr;
  logic [1:0] irq_set;
  logic [1:0] irq_clr;
  logic [7:0] rd;

  always_comb begin
    state_d = state_q;
    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    req = wb_cyc_in && wb_stb_in && !state_q.ack;
    wr = req && wb_we_in && wb_sel_in[0];
    idx = wb_adr_in[9:2];
    wbyte = wb_dat_in[7:0];

    // ----------------------------------------------------------------
    // Event detection
    // ----------------------------------------------------------------
    // [R17] Edges from consecutive synchronised samples
    rise = result_sync && !state_q.result_prev;
    fall = !result_sync && state_q.result_prev;
    // [R3] [R17] Mode decode, reserved never fires
    case (state_q.event_mode)
      analog_comparator_pkg::MODE_TOGGLE: hit = rise | fall;
      analog_comparator_pkg::MODE_FALL: hit = fall;
      analog_comparator_pkg::MODE_RISE: hit = rise;
      default: hit = 1'b0;
    endcase
    state_d.result_prev = result_sync;

    // ----------------------------------------------------------------
    // Flags and interrupt status
    // ----------------------------------------------------------------
    // [R5] Flag clear by vector or by written one
    flag_clr = vector_taken_in || (write_hits(wr, idx, `ACC_IDX_CMP_CTRL) && wbyte[`ACC_BIT_FLAG]);
    // [R4] Flag set on matching event
    state_d.flag = sticky_next(state_q.flag, hit, flag_clr);

    irq_set = 2'b00;
    irq_set[`ACC_BIT_IRQ_EVENT] = hit;
    // Change bit fires in every mode, reserved too, for polling software
    irq_set[`ACC_BIT_IRQ_CHANGE] = rise | fall;
    irq_clr = write_hits(wr, idx, `ACC_IDX_IRQ_STATUS) ? wbyte[1:0] : 2'b00;
    state_d.irq_status[0] = sticky_next(state_q.irq_status[0], irq_set[0], irq_clr[0]);
    state_d.irq_status[1] = sticky_next(state_q.irq_status[1], irq_set[1], irq_clr[1]);

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // A write with byte lane 0 off is acked but changes nothing
    if (wr) begin
      case (idx)
        `ACC_IDX_CMP_CTRL: begin
          // [R7] Power control
          state_d.power_off = wbyte[`ACC_BIT_POWER_OFF];
          state_d.bandgap_sel = wbyte[`ACC_BIT_BANDGAP];
          state_d.irq_en = wbyte[`ACC_BIT_IRQ_EN];
          state_d.capture_route = wbyte[`ACC_BIT_CAPTURE];
          state_d.event_mode = analog_comparator_pkg::event_mode_t'(wbyte[`ACC_BIT_MODE_HI:`ACC_BIT_MODE_LO]);
        end
        `ACC_IDX_CONV_B: begin
          // [R14] Only mux enable and trigger select are stored
          state_d.mux_en = wbyte[`ACC_BIT_MUX_EN];
          state_d.trig_sel = wbyte[`ACC_BIT_TRIG_HI:`ACC_BIT_TRIG_LO];
        end
        `ACC_IDX_DIG_DIS: begin
          state_d.neg_buf_dis = wbyte[`ACC_BIT_NEG_DIS];
          state_d.pos_buf_dis = wbyte[`ACC_BIT_POS_DIS];
        end
        `ACC_IDX_IRQ_MASK: begin
          state_d.irq_mask = wbyte[1:0];
        end
        default: begin
        end
      endcase
    end

    // ----------------------------------------------------------------
    // Register reads
    // ----------------------------------------------------------------
    // Register reads, unmapped indices read zero
    rd = `ACC_RST_BYTE;
    case (idx)
      `ACC_IDX_CMP_CTRL: begin
        rd[`ACC_BIT_POWER_OFF] = state_q.power_off;
        rd[`ACC_BIT_BANDGAP] = state_q.bandgap_sel;
        rd[`ACC_BIT_RESULT] = result_sync;
        rd[`ACC_BIT_FLAG] = state_q.flag;
        rd[`ACC_BIT_IRQ_EN] = state_q.irq_en;
        rd[`ACC_BIT_CAPTURE] = state_q.capture_route;
        rd[`ACC_BIT_MODE_HI:`ACC_BIT_MODE_LO] = state_q.event_mode;
      end
      `ACC_IDX_CONV_B: begin
        // [R14] Unused bits read zero
        rd[`ACC_BIT_MUX_EN] = state_q.mux_en;
        rd[`ACC_BIT_TRIG_HI:`ACC_BIT_TRIG_LO] = state_q.trig_sel;
      end
      `ACC_IDX_DIG_DIS: begin
        rd[`ACC_BIT_NEG_DIS] = state_q.neg_buf_dis;
        rd[`ACC_BIT_POS_DIS] = state_q.pos_buf_dis;
      end
      `ACC_IDX_IRQ_STATUS: rd[1:0] = state_q.irq_status;
      `ACC_IDX_IRQ_MASK: rd[1:0] = state_q.irq_mask;
      default: rd = `ACC_RST_BYTE;
    endcase

    // ----------------------------------------------------------------
    // Bus answer
    // ----------------------------------------------------------------
    // Read data registered at the request edge, valid with ack
    // Ack one cycle after the request, dropped the cycle after
    state_d.ack = req;
    if (req) begin
      state_d.rdata = rd;
    end

    // ----------------------------------------------------------------
    // Output-side state
    // ----------------------------------------------------------------
    // [R10] Capture route gate
    state_d.capture = state_q.capture_route && result_sync;
    // Next flag used, so a vector clear leaves no stale request cycle
    // [R6] Comparator interrupt request
    state_d.irq_req = state_d.flag && state_d.irq_en && global_irq_enable_in;
    state_d.irq_line = |(state_d.irq_status & state_d.irq_mask);
    // Next disable value, so port bits drop with the write itself
    // [R16] Disabled pin buffers read zero
    state_d.port_pins = {sync_q[2] & ~state_d.neg_buf_dis, sync_q[1] & ~state_d.pos_buf_dis};
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_out = state_q.ack;
  assign wb_dat_out = {24'h000000, state_q.rdata};
  assign comparator_result_out = result_sync;
  assign capture_trigger_out = state_q.capture;
  assign compare_irq_request_out = state_q.irq_req;
  assign irq_out = state_q.irq_line;
  assign comparator_power_off_out = state_q.power_off;
  assign trigger_select_out = state_q.trig_sel;
  assign positive_pin_buffer_disable_out = state_q.pos_buf_dis;
  assign negative_pin_buffer_disable_out = state_q.neg_buf_dis;
  assign port_pins_out = state_q.port_pins;

endmodule // analog_comparator_control

// file: test/analog_comparator_control_props.sv
// Port timing checker for the comparator control block
`timescale 1ns/1ps
module analog_comparator_control_props (
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_ack_out,
  input wire logic global_irq_enable_in,
  input wire logic vector_taken_in,
  input wire logic comparator_result_out,
  input wire logic capture_trigger_out,
  input wire logic compare_irq_request_out,
  input wire logic comparator_power_off_out,
  input wire logic positive_pin_buffer_disable_out,
  input wire logic [1:0] port_pins_out
);
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (reset_in);
  a_ack_next: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack late");
  a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held");
  a_ack_cause: assert property (!(wb_cyc_in && wb_stb_in) |=> !wb_ack_out)
    else $error("ack without request");
  a_capture_gate: assert property (capture_trigger_out |-> $past(comparator_result_out))
    else $error("capture without result");
  a_irq_global: assert property (compare_irq_request_out |-> $past(global_irq_enable_in))
    else $error("request without global enable");
  a_vector_clear: assert property (vector_taken_in && $stable(comparator_result_out)
    |=> !compare_irq_request_out) else $error("flag kept after vector");
  a_power_low: assert property (comparator_power_off_out [*5] |-> !comparator_result_out)
    else $error("result while powered off");
  a_port_zero: assert property (positive_pin_buffer_disable_out [*5] |-> !port_pins_out[0])
    else $error("port bit with buffer off");
endmodule // analog_comparator_control_props

bind analog_comparator_control analog_comparator_control_props props_u (.*);

// file: test/analog_pin_model.sv
// Analog pin levels and timer capture front end facing the comparator block
`timescale 1ns/1ps
module analog_pin_model (
  input wire logic clk_sys_in,
  input wire logic capture_trigger_in,
  output logic [9:0] pos_lvl_out,
  output logic [9:0] neg_lvl_out,
  output logic [79:0] chan_lvl_out
);
  logic capture_irq_enable_q = 1'b0;
  logic cap_prev_q = 1'b0;
  logic converter_power_reduce_q = 1'b0;
  int capture_cnt = 0;
  initial begin
    pos_lvl_out = 10'h000;
    neg_lvl_out = 10'h000;
    chan_lvl_out = 80'h0;
  end
  task automatic drive(input logic [9:0] p, input logic [9:0] n, input logic [79:0] c);
    @(posedge clk_sys_in);
    pos_lvl_out <= p;
    neg_lvl_out <= n;
    chan_lvl_out <= c;
  endtask
  always @(posedge clk_sys_in) begin
    cap_prev_q <= capture_trigger_in;
    if (capture_irq_enable_q && !converter_power_reduce_q && capture_trigger_in && !cap_prev_q)
      capture_cnt <= capture_cnt + 1;
  end
endmodule // analog_pin_model

// file: test/analog_comparator_control_tb.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
module analog_comparator_control_tb;
  logic clk_sys_in, reset_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic [9:0] wb_adr_in, positive_input_pin_in, negative_input_pin_in;
  logic [3:0] wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out;
  logic [79:0] analog_channel_pins_in;
  logic positive_pin_digital_in, negative_pin_digital_in, converter_enable_in;
  logic global_irq_enable_in, vector_taken_in, comparator_result_out, capture_trigger_out;
  logic compare_irq_request_out, irq_out, comparator_power_off_out;
  logic positive_pin_buffer_disable_out, negative_pin_buffer_disable_out;
  logic [2:0] channel_select_in, trigger_select_out;
  logic [1:0] port_pins_out;
  logic [7:0] q;
  int error_cnt = 0;
  int n_tests = 0;
  analog_comparator_control dut_u (.clk_sys_in, .reset_in, .wb_cyc_in, .wb_stb_in, .wb_we_in,
    .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_dat_out, .wb_ack_out, .positive_input_pin_in,
    .negative_input_pin_in, .analog_channel_pins_in, .positive_pin_digital_in,
    .negative_pin_digital_in, .converter_enable_in, .channel_select_in, .global_irq_enable_in,
    .vector_taken_in, .comparator_result_out, .capture_trigger_out, .compare_irq_request_out,
    .irq_out, .comparator_power_off_out, .trigger_select_out, .positive_pin_buffer_disable_out,
    .negative_pin_buffer_disable_out, .port_pins_out);
  analog_pin_model pins_u (.clk_sys_in, .capture_trigger_in(capture_trigger_out),
    .pos_lvl_out(positive_input_pin_in), .neg_lvl_out(negative_input_pin_in),
    .chan_lvl_out(analog_channel_pins_in));
  initial begin
    clk_sys_in = 1'b0;
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %0t got %0h exp %0h", $time, g, e);
    end
  endtask
  task automatic chb(input logic g, input logic e);
    chk({7'h00, g}, {7'h00, e});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys_in);
    #1;
  endtask
  // Classic cycle, held until ack is sampled
  task automatic bus(input logic [9:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= w;
    wb_adr_in <= a;
    wb_dat_in <= {24'h000000, d};
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 50);
    q = wb_dat_out[7:0];
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    if (n >= 50) chk(8'h00, 8'hFF);
  endtask
  task automatic lvl(input logic r);
    pins_u.drive(r ? 10'h200 : 10'h000, 10'h100, 80'h0);
    wt(6);
  endtask
  task automatic t_regs();
    bus(10'h1EC, 1'b0, 8'h00); chk(q, 8'h00);
    bus(10'h1EC, 1'b1, 8'hFF);
    bus(10'h1EC, 1'b0, 8'h00); chk(q, 8'h47);
    chk({5'h00, trigger_select_out}, 8'h07);
    bus(10'h1EC, 1'b1, 8'h00);
    bus(10'h3FC, 1'b0, 8'h00); chk(q, 8'h00);
    bus(10'h0C0, 1'b0, 8'h00); chk(q, 8'h00);
  endtask
  task automatic t_sync();
    pins_u.drive(10'h101, 10'h100, 80'h0);
    #1 chb(comparator_result_out, 1'b0);
    wt(2); chb(comparator_result_out, 1'b1);
    pins_u.drive(10'h100, 10'h100, 80'h0);
    wt(3); chb(comparator_result_out, 1'b0);
    bus(10'h0C0, 1'b1, 8'h40);
    pins_u.drive(10'h000, 10'h167, 80'h0);
    wt(3); chb(comparator_result_out, 1'b1);
    pins_u.drive(10'h000, 10'h168, 80'h0);
    wt(3); chb(comparator_result_out, 1'b0);
    bus(10'h0C0, 1'b1, 8'h00);
  endtask
  task automatic t_mux();
    bus(10'h1EC, 1'b1, 8'h40);
    for (int k = 0; k < 8; k++) begin
      pins_u.drive(10'h200, 10'h000, 80'h3FF << (k * 10));
      channel_select_in <= k[2:0];
      wt(4); chb(comparator_result_out, 1'b0);
      @(posedge clk_sys_in);
      channel_select_in <= k[2:0] + 3'h1;
      wt(4); chb(comparator_result_out, 1'b1);
      channel_select_in <= k[2:0];
      converter_enable_in <= 1'b1;
      wt(4); chb(comparator_result_out, 1'b1);
      converter_enable_in <= 1'b0;
    end
    bus(10'h1EC, 1'b1, 8'h00);
    wt(4); chb(comparator_result_out, 1'b1);
  endtask
  task automatic t_events();
    logic fr, ff;
    lvl(1'b0);
    for (int i = 0; i < 4; i++) begin
      fr = (i == 0 || i == 3);
      ff = (i == 0 || i == 2);
      bus(10'h0C0, 1'b1, 8'h10 | i[7:0]);
      bus(10'h104, 1'b1, 8'h03);
      lvl(1'b1);
      bus(10'h0C0, 1'b0, 8'h00); chk(q, {3'h1, fr, 2'h0, i[1:0]});
      bus(10'h0C0, 1'b1, 8'h10 | i[7:0]);
      lvl(1'b0);
      bus(10'h0C0, 1'b0, 8'h00); chk(q, {3'h0, ff, 2'h0, i[1:0]});
      bus(10'h104, 1'b0, 8'h00); chk(q, {6'h00, 1'b1, fr | ff});
    end
    bus(10'h108, 1'b1, 8'h01);
    bus(10'h0C0, 1'b1, 8'h1B);
    bus(10'h104, 1'b1, 8'h03);
    global_irq_enable_in <= 1'b1;
    lvl(1'b1); chb(compare_irq_request_out, 1'b1);
    chb(irq_out, 1'b1);
    global_irq_enable_in <= 1'b0;
    wt(2); chb(compare_irq_request_out, 1'b0);
    global_irq_enable_in <= 1'b1;
    bus(10'h0C0, 1'b1, 8'h0B);
    wt(2); chb(compare_irq_request_out, 1'b1);
    vector_taken_in <= 1'b1;
    @(posedge clk_sys_in);
    vector_taken_in <= 1'b0;
    wt(2); chb(compare_irq_request_out, 1'b0);
    bus(10'h108, 1'b1, 8'h00);
    wt(2); chb(irq_out, 1'b0);
    bus(10'h108, 1'b1, 8'h01);
    wt(2); chb(irq_out, 1'b1);
    bus(10'h104, 1'b1, 8'h03);
    wt(2); chb(irq_out, 1'b0);
    bus(10'h0C0, 1'b1, 8'h00);
  endtask
  task automatic t_power();
    pins_u.capture_irq_enable_q = 1'b1;
    bus(10'h0C0, 1'b1, 8'h80);
    wt(6); chb(comparator_result_out, 1'b0);
    chb(comparator_power_off_out, 1'b1);
    bus(10'h0C0, 1'b1, 8'h04);
    wt(6); chb(comparator_result_out, 1'b1);
    chb(capture_trigger_out, 1'b1);
    chk(pins_u.capture_cnt[7:0], 8'h01);
    bus(10'h0C0, 1'b1, 8'h00);
    wt(3); chb(capture_trigger_out, 1'b0);
  endtask
  task automatic t_pins();
    positive_pin_digital_in <= 1'b1;
    negative_pin_digital_in <= 1'b1;
    wt(5); chk({6'h00, port_pins_out}, 8'h03);
    bus(10'h100, 1'b1, 8'h03);
    wt(5); chk({6'h00, port_pins_out}, 8'h00);
    chb(negative_pin_buffer_disable_out, 1'b1);
    chb(positive_pin_buffer_disable_out, 1'b1);
    bus(10'h100, 1'b1, 8'h01);
    wt(5); chk({6'h00, port_pins_out}, 8'h02);
  endtask
  task automatic summarize();
    if (error_cnt == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    reset_in = 1'b1;
    {wb_cyc_in, wb_stb_in, wb_we_in, vector_taken_in, converter_enable_in} = 5'h00;
    {positive_pin_digital_in, negative_pin_digital_in, global_irq_enable_in} = 3'h0;
    wb_adr_in = 10'h000;
    wb_dat_in = 32'h0;
    wb_sel_in = 4'hF;
    channel_select_in = 3'h0;
    repeat (20) @(posedge clk_sys_in);
    reset_in <= 1'b0;
    t_regs();
    t_sync();
    t_mux();
    t_events();
    t_power();
    t_pins();
    summarize();
  end
  // Run needs about 420 cycles
  initial begin
    #200000;
    error_cnt++;
    summarize();
  end
endmodule // analog_comparator_control_tb
